// *** shared/scc_pkg.sv ***
package scc_pkg;
	localparam int          ADDR_W           = 20;
	localparam logic [19:0] ADDR_OPTION      = 20'h000C2;
	localparam logic [19:0] ADDR_DIVIDER     = 20'hF00A8;
	localparam logic [19:0] ADDR_SPEED_MODE  = 20'hF00F3;
	localparam logic [19:0] ADDR_CLK_MODE    = 20'hF00E0;
	localparam logic [19:0] ADDR_CLK_STATUS  = 20'hF00E1;
	localparam logic [19:0] ADDR_STAB_STATUS = 20'hF00E2;
	localparam logic [19:0] ADDR_SYS_CLK     = 20'hF00E3;
	localparam logic [19:0] ADDR_STATE       = 20'hF00E4;

	localparam int EXT_CLK_BIT   = 7;
	localparam int OSC_PIN_BIT   = 6;
	localparam int MAIN_STOP_BIT = 7;
	localparam int FAST_STOP_BIT = 0;
	localparam int SLOW_EN_BIT   = 4;
	localparam int MAIN_REQ_BIT  = 4;
	localparam int MAIN_ACT_BIT  = 5;
	localparam int FLASH_HI_BIT  = 7;
	localparam int FLASH_LO_BIT  = 6;
	localparam int FREQ_HI_BIT   = 4;
	localparam int FREQ_RAW_BIT  = 4;
	localparam int DIV_W         = 3;

	localparam logic [1:0] MAIN_MODE_PORT   = 2'h0;
	localparam logic [1:0] MAIN_MODE_XTAL   = 2'h1;
	localparam logic [1:0] MAIN_MODE_EXT    = 2'h3;
	localparam logic [1:0] FLASH_LOW_SPEED  = 2'h2;
	localparam logic [1:0] FLASH_HIGH_SPEED = 2'h3;

	localparam logic [7:0] CLK_MODE_RST   = 8'h00;
	localparam logic [7:0] CLK_STATUS_RST = 8'h80;
	localparam logic [7:0] SPEED_MODE_RST = 8'h00;
	localparam logic [7:0] SYS_CLK_RST    = 8'h00;

	localparam int CLK_PERIOD_NS      = 25;
	localparam int HOCO_STAB_NS_STD   = 65000;
	localparam int HOCO_STAB_NS_RAW48 = 135000;
	localparam int HOCO_STAB_CYC_STD  =
		(HOCO_STAB_NS_STD + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOCO_STAB_CYC_RAW48 =
		(HOCO_STAB_NS_RAW48 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] SWITCH_OLD_CYC  = 2'h3;
	localparam logic [1:0] SWITCH_WAIT_CYC = 2'h3;
	localparam logic [1:0] SYNC_CYC        = 2'h3;
	localparam int         MAIN_STAB_STEP  = 256;

	typedef enum logic [1:0] {RP_SYNC, RP_STAB, RP_DONE} scc_reset_state_type;
	typedef enum logic [1:0] {SW_IDLE, SW_OLD, SW_WAIT} scc_switch_state_type;
endpackage

// *** rtl/scc_clock_source_ctrl.sv ***
// The strobed register port is this design's own decision.
module scc_clock_source_ctrl #(
	parameter int HOCO_STAB_STD   = scc_pkg::HOCO_STAB_CYC_STD,
	parameter int HOCO_STAB_RAW48 = scc_pkg::HOCO_STAB_CYC_RAW48,
	parameter int STAB_STEP       = scc_pkg::MAIN_STAB_STEP
) (
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_NRST,
	input  wire logic [19:0] I_ADDR,
	input  wire logic [7:0]  I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [7:0]  O_RDATA,
	input  wire logic [7:0]  I_OPTION_BYTE,
	input  wire logic        I_WATCHDOG_ON_OPTION,
	input  wire logic        I_WATCHDOG_STANDBY_RUN,
	input  wire logic        I_STANDBY,
	output logic             O_CPU_START,
	output logic             O_CPU_CLK_GATE,
	output logic             O_CPU_SRC_MAIN,
	output logic             O_FAST_OSC_RUN,
	output logic      [4:0]  O_FAST_OSC_FREQ_SEL,
	output logic      [2:0]  O_FAST_OSC_DIV,
	output logic             O_FAST_OSC_HALVE,
	output logic             O_XTAL_AMP_EN,
	output logic             O_EXT_CLK_IN_EN,
	output logic             O_XTAL_PORT_MODE,
	output logic             O_SLOW_OSC_RUN,
	output logic             O_SLOW_TO_WDT,
	output logic             O_SLOW_TO_TIMERS,
	output logic             O_FLASH_HIGH_SPEED,
	output logic             O_FLASH_MODE_ERR
);
	localparam logic [15:0] STAB_STD_W   = 16'(HOCO_STAB_STD);
	localparam logic [15:0] STAB_RAW48_W = 16'(HOCO_STAB_RAW48);
	localparam logic [15:0] STAB_FULL_W  = 16'(8 * STAB_STEP);

	// straps come from outside the clock domain
	logic [9:0]                    strap_meta;
	logic [9:0]                    strap_sync;
	logic [7:0]                    option;
	logic                          wdt_on;
	logic                          wdt_standby;
	scc_pkg::scc_reset_state_type  rp_state;
	scc_pkg::scc_reset_state_type  next_rp_state;
	logic [15:0]                   rp_cnt;
	logic [15:0]                   next_rp_cnt;
	scc_pkg::scc_switch_state_type sw_state;
	scc_pkg::scc_switch_state_type next_sw_state;
	logic [1:0]                    sw_cnt;
	logic [1:0]                    next_sw_cnt;
	logic [1:0]                    main_mode;
	logic                          mode_locked;
	logic                          main_stop;
	logic                          fast_stop;
	logic                          slow_en;
	logic [2:0]                    div_sw;
	logic [2:0]                    div_eff;
	logic                          src_sw;
	logic                          src_eff;
	logic [15:0]                   stab_cnt;
	logic [7:0]                    stab_bits;

	wire logic        capture     = (rp_state == scc_pkg::RP_SYNC) &&
		(rp_cnt[1:0] == scc_pkg::SYNC_CYC - 2'h1);
	wire logic        cpu_started = (rp_state == scc_pkg::RP_DONE);
	wire logic [15:0] stab_limit  = option[scc_pkg::FREQ_RAW_BIT] ?
		STAB_RAW48_W : STAB_STD_W;
	wire logic xtal_running = (main_mode == scc_pkg::MAIN_MODE_XTAL) &&
		!main_stop;
	wire logic ext_running  = (main_mode == scc_pkg::MAIN_MODE_EXT) &&
		!main_stop;
	wire logic stab_full    = (stab_cnt >= STAB_FULL_W);
	// external clock is usable at once, resonator only once settled
	wire logic main_ready   = ext_running || (xtal_running && stab_full);

	wire logic hit_mode   = (I_ADDR == scc_pkg::ADDR_CLK_MODE);
	wire logic hit_status = (I_ADDR == scc_pkg::ADDR_CLK_STATUS);
	wire logic hit_speed  = (I_ADDR == scc_pkg::ADDR_SPEED_MODE);
	wire logic hit_div    = (I_ADDR == scc_pkg::ADDR_DIVIDER);
	wire logic hit_stab   = (I_ADDR == scc_pkg::ADDR_STAB_STATUS);
	wire logic hit_sys    = (I_ADDR == scc_pkg::ADDR_SYS_CLK);
	wire logic hit_state  = (I_ADDR == scc_pkg::ADDR_STATE);
	wire logic hit_option = (I_ADDR == scc_pkg::ADDR_OPTION);

	// mode register may be set once only after reset
	wire logic wr_mode   = I_WR && hit_mode && !mode_locked;
	wire logic wr_status = I_WR && hit_status;
	wire logic wr_speed  = I_WR && hit_speed;
	// refused unless the fast oscillator is both the requested and the running source
	wire logic wr_div    = I_WR && hit_div && !src_sw && !src_eff;
	// switching to main refused until the main clock is ready
	wire logic req_main  = I_WDATA[scc_pkg::MAIN_REQ_BIT];
	wire logic wr_sys    = I_WR && hit_sys &&
		(!req_main || main_ready);

	wire logic changed = (div_sw != div_eff) || (src_sw != src_eff);

	wire logic [7:0] rd_mode   = {main_mode, 6'h00};
	wire logic [7:0] rd_status = {main_stop, 6'h00, fast_stop};
	wire logic [7:0] rd_speed  = {3'h0, slow_en, 4'h0};
	wire logic [7:0] rd_div    = {5'h00, div_sw};
	wire logic [7:0] rd_sys    = {2'h0, src_eff, src_sw, 4'h0};
	wire logic [7:0] rd_state  = {4'h0, main_ready,
		O_SLOW_OSC_RUN, (sw_state != scc_pkg::SW_IDLE), cpu_started};
	wire logic [7:0] rd_value  =
		hit_mode   ? rd_mode   :
		hit_status ? rd_status :
		hit_speed  ? rd_speed  :
		hit_div    ? rd_div    :
		hit_stab   ? stab_bits :
		hit_sys    ? rd_sys    :
		hit_state  ? rd_state  :
		hit_option ? option    : 8'h00;

	// slow oscillator: either enable runs it, standby may stop it
	wire logic slow_stop_cond = wdt_on && !slow_en && !wdt_standby &&
		I_STANDBY;
	wire logic next_slow_run  = (wdt_on || slow_en) && !slow_stop_cond;

	wire logic [1:0] flash_mode =
		option[scc_pkg::FLASH_HI_BIT:scc_pkg::FLASH_LO_BIT];
	wire logic next_flash_high = (flash_mode == scc_pkg::FLASH_HIGH_SPEED);
	wire logic next_flash_err  = (flash_mode != scc_pkg::FLASH_LOW_SPEED) &&
		!next_flash_high;

	// cpu clock may only be taken from the fast oscillator or main clock
	wire logic next_gate = cpu_started && (sw_state != scc_pkg::SW_WAIT);
	// never stop the fast oscillator while it clocks the cpu
	wire logic next_fast_run = !fast_stop || !src_eff;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_stab
			localparam logic [15:0] STEP_LIMIT = 16'((gi + 1) * STAB_STEP);
			assign stab_bits[7 - gi] = (stab_cnt >= STEP_LIMIT);
		end
	endgenerate

	always_comb begin
		next_rp_state = rp_state;
		next_rp_cnt = rp_cnt + 16'h0001;
		unique case (rp_state)
			scc_pkg::RP_SYNC: begin
				if (capture) begin
					next_rp_state = scc_pkg::RP_STAB;
					next_rp_cnt = 16'h0000;
				end
			end
			scc_pkg::RP_STAB: begin
				// cpu held until accuracy has settled
				if (rp_cnt >= stab_limit - 16'h0001) begin
					next_rp_state = scc_pkg::RP_DONE;
					next_rp_cnt = 16'h0000;
				end
			end
			scc_pkg::RP_DONE: begin
				next_rp_cnt = 16'h0000;
			end
		endcase
	end

	always_comb begin
		next_sw_state = sw_state;
		next_sw_cnt = sw_cnt + 2'h1;
		unique case (sw_state)
			scc_pkg::SW_IDLE: begin
				next_sw_cnt = 2'h0;
				if (changed && cpu_started) begin
					next_sw_state = scc_pkg::SW_OLD;
				end
			end
			scc_pkg::SW_OLD: begin
				if (sw_cnt == scc_pkg::SWITCH_OLD_CYC - 2'h1) begin
					next_sw_state = scc_pkg::SW_WAIT;
					next_sw_cnt = 2'h0;
				end
			end
			scc_pkg::SW_WAIT: begin
				if (sw_cnt == scc_pkg::SWITCH_WAIT_CYC - 2'h1) begin
					next_sw_state = scc_pkg::SW_IDLE;
					next_sw_cnt = 2'h0;
				end
			end
			default: begin
				next_sw_state = scc_pkg::SW_IDLE;
				next_sw_cnt = 2'h0;
			end
		endcase
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			strap_meta <= 10'h000;
			strap_sync <= 10'h000;
		end else begin
			strap_meta <= {I_WATCHDOG_STANDBY_RUN, I_WATCHDOG_ON_OPTION,
				I_OPTION_BYTE};
			strap_sync <= strap_meta;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			option <= 8'h00;
			wdt_on <= 1'b0;
			wdt_standby <= 1'b0;
		end else if (capture) begin
			option <= strap_sync[7:0];
			wdt_on <= strap_sync[8];
			wdt_standby <= strap_sync[9];
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rp_state <= scc_pkg::RP_SYNC;
			rp_cnt <= 16'h0000;
			sw_state <= scc_pkg::SW_IDLE;
			sw_cnt <= 2'h0;
		end else begin
			rp_state <= next_rp_state;
			rp_cnt <= next_rp_cnt;
			sw_state <= next_sw_state;
			sw_cnt <= next_sw_cnt;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			main_mode <= scc_pkg::CLK_MODE_RST[7:6];
			mode_locked <= 1'b0;
		end else if (wr_mode) begin
			main_mode <= {I_WDATA[scc_pkg::EXT_CLK_BIT],
				I_WDATA[scc_pkg::OSC_PIN_BIT]};
			mode_locked <= 1'b1;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			main_stop <= scc_pkg::CLK_STATUS_RST[scc_pkg::MAIN_STOP_BIT];
			fast_stop <= scc_pkg::CLK_STATUS_RST[scc_pkg::FAST_STOP_BIT];
		end else if (wr_status) begin
			main_stop <= I_WDATA[scc_pkg::MAIN_STOP_BIT];
			fast_stop <= I_WDATA[scc_pkg::FAST_STOP_BIT];
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			slow_en <= scc_pkg::SPEED_MODE_RST[scc_pkg::SLOW_EN_BIT];
		end else if (wr_speed) begin
			slow_en <= I_WDATA[scc_pkg::SLOW_EN_BIT];
		end
	end

	// software view and applied view are split so a change waits for a
	// clean switch point instead of cutting a clock phase
	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			div_sw <= 3'h0;
			src_sw <= scc_pkg::SYS_CLK_RST[scc_pkg::MAIN_REQ_BIT];
		end else if (capture) begin
			div_sw <= strap_sync[scc_pkg::DIV_W-1:0];
		end else begin
			if (wr_div) begin
				div_sw <= I_WDATA[scc_pkg::DIV_W-1:0];
			end
			if (wr_sys) begin
				src_sw <= req_main;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			div_eff <= 3'h0;
			src_eff <= scc_pkg::SYS_CLK_RST[scc_pkg::MAIN_ACT_BIT];
		end else if (capture) begin
			div_eff <= strap_sync[scc_pkg::DIV_W-1:0];
		end else if (next_sw_state == scc_pkg::SW_WAIT &&
			sw_state == scc_pkg::SW_OLD) begin
			div_eff <= div_sw;
			src_eff <= src_sw;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			stab_cnt <= 16'h0000;
		end else if (!xtal_running) begin
			stab_cnt <= 16'h0000;
		end else if (!stab_full) begin
			stab_cnt <= stab_cnt + 16'h0001;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_RDATA <= 8'h00;
		end else begin
			O_RDATA <= I_RD ? rd_value : 8'h00;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_CPU_START <= 1'b0;
			O_CPU_CLK_GATE <= 1'b0;
			O_CPU_SRC_MAIN <= 1'b0;
			O_FAST_OSC_RUN <= 1'b1;
			O_FAST_OSC_FREQ_SEL <= 5'h00;
			O_FAST_OSC_DIV <= 3'h0;
			O_FAST_OSC_HALVE <= 1'b0;
			O_XTAL_AMP_EN <= 1'b0;
			O_EXT_CLK_IN_EN <= 1'b0;
			O_XTAL_PORT_MODE <= 1'b1;
			O_SLOW_OSC_RUN <= 1'b0;
			O_SLOW_TO_WDT <= 1'b0;
			O_SLOW_TO_TIMERS <= 1'b0;
			O_FLASH_HIGH_SPEED <= 1'b0;
			O_FLASH_MODE_ERR <= 1'b0;
		end else begin
			O_CPU_START <= cpu_started;
			O_CPU_CLK_GATE <= next_gate;
			O_CPU_SRC_MAIN <= src_eff;
			O_FAST_OSC_RUN <= next_fast_run;
			O_FAST_OSC_FREQ_SEL <= option[scc_pkg::FREQ_HI_BIT:0];
			O_FAST_OSC_DIV <= div_eff;
			// raw 48 MHz setting always reaches the cpu halved
			O_FAST_OSC_HALVE <= option[scc_pkg::FREQ_RAW_BIT];
			O_XTAL_AMP_EN <= xtal_running;
			O_EXT_CLK_IN_EN <= ext_running;
			O_XTAL_PORT_MODE <= (main_mode == scc_pkg::MAIN_MODE_PORT);
			O_SLOW_OSC_RUN <= next_slow_run;
			O_SLOW_TO_WDT <= next_slow_run && wdt_on;
			O_SLOW_TO_TIMERS <= next_slow_run && slow_en;
			O_FLASH_HIGH_SPEED <= next_flash_high;
			O_FLASH_MODE_ERR <= next_flash_err;
		end
	end
endmodule

// *** verif/scc_xtal_source_model.sv ***
module scc_xtal_source_model #(
	parameter int HALF_NS = 50
) (
	input  wire logic i_amp_en,
	input  wire logic i_ext_en,
	output logic      o_xtal_clock
);
	timeunit 1ns;
	timeprecision 100ps;
	initial o_xtal_clock = 1'b0;
	// resonator and pin source both ready at once; idle clock parks low
	always begin
		#HALF_NS;
		if (i_amp_en || i_ext_en)
			o_xtal_clock = ~o_xtal_clock;
		else
			o_xtal_clock = 1'b0;
	end
endmodule

// *** verif/scc_clock_source_ctrl_sva.sv ***
module scc_clock_source_ctrl_sva #(
	parameter int HOCO_STAB_STD = 8
) (
	input wire logic        I_SYS_CLK,
	input wire logic        I_NRST,
	input wire logic [19:0] I_ADDR,
	input wire logic [7:0]  I_WDATA,
	input wire logic        I_WR,
	input wire logic        I_STANDBY,
	input wire logic        O_CPU_START,
	input wire logic        O_CPU_CLK_GATE,
	input wire logic        O_CPU_SRC_MAIN,
	input wire logic        O_FAST_OSC_RUN,
	input wire logic [2:0]  O_FAST_OSC_DIV,
	input wire logic        O_XTAL_AMP_EN,
	input wire logic        O_EXT_CLK_IN_EN,
	input wire logic        O_XTAL_PORT_MODE,
	input wire logic        O_SLOW_OSC_RUN,
	input wire logic        O_SLOW_TO_WDT,
	input wire logic        O_SLOW_TO_TIMERS,
	input wire logic        O_FLASH_HIGH_SPEED,
	input wire logic        O_FLASH_MODE_ERR
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] rel_cnt;
	logic [2:0]  last_div;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_NRST);
	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST)
			rel_cnt <= 16'h0000;
		else if (rel_cnt != 16'hFFFF)
			rel_cnt <= rel_cnt + 16'h0001;
	end
	always_ff @(posedge I_SYS_CLK) begin
		if (I_WR && I_ADDR == scc_pkg::ADDR_DIVIDER)
			last_div <= I_WDATA[2:0];
	end
	// only writes on a settled fast source are expected to apply
	sequence s_div_wr;
		I_WR && I_ADDR == scc_pkg::ADDR_DIVIDER && O_CPU_START &&
		!O_CPU_SRC_MAIN && O_CPU_CLK_GATE;
	endsequence
	sequence s_gate_wait;
		!O_CPU_CLK_GATE [*3] ##1 O_CPU_CLK_GATE;
	endsequence
	a_xtal_mode_excl: assert property (
		O_XTAL_AMP_EN |-> !O_EXT_CLK_IN_EN && !O_XTAL_PORT_MODE)
		else $error("resonator mode overlaps another mode");
	a_slow_feed_only: assert property (
		O_SLOW_TO_WDT || O_SLOW_TO_TIMERS |-> O_SLOW_OSC_RUN)
		else $error("slow clock fed while stopped");
	a_wdt_keeps_slow: assert property (
		O_SLOW_TO_WDT && !I_STANDBY |=> O_SLOW_OSC_RUN)
		else $error("slow clock stopped under watchdog");
	a_start_after_stab: assert property (
		$rose(O_CPU_START) |-> rel_cnt > HOCO_STAB_STD)
		else $error("cpu started before accuracy wait");
	a_start_on_fast: assert property (
		$rose(O_CPU_START) |-> !O_CPU_SRC_MAIN && O_FAST_OSC_RUN)
		else $error("cpu not started on fast oscillator");
	a_gate_wait_len: assert property (
		$fell(O_CPU_CLK_GATE) |-> s_gate_wait)
		else $error("switch wait not three cycles");
	a_div_apply: assert property (
		s_div_wr |-> ##[1:8] O_FAST_OSC_DIV == last_div)
		else $error("divider write not applied");
	a_flash_excl: assert property (
		O_FLASH_HIGH_SPEED |-> !O_FLASH_MODE_ERR)
		else $error("flash mode both high speed and error");
	a_fast_keep: assert property (
		O_CPU_START && !O_CPU_SRC_MAIN |-> O_FAST_OSC_RUN)
		else $error("fast oscillator stopped while clocking cpu");
	a_switch_gated: assert property (
		O_CPU_START && ($changed(O_CPU_SRC_MAIN) ||
		$changed(O_FAST_OSC_DIV)) |-> !O_CPU_CLK_GATE)
		else $error("clock source changed with gate open");
endmodule

bind scc_clock_source_ctrl scc_clock_source_ctrl_sva #(
	.HOCO_STAB_STD(HOCO_STAB_STD)
) u_sva (
	.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_STANDBY(I_STANDBY),
	.O_CPU_START(O_CPU_START), .O_CPU_CLK_GATE(O_CPU_CLK_GATE),
	.O_CPU_SRC_MAIN(O_CPU_SRC_MAIN), .O_FAST_OSC_RUN(O_FAST_OSC_RUN),
	.O_FAST_OSC_DIV(O_FAST_OSC_DIV), .O_XTAL_AMP_EN(O_XTAL_AMP_EN),
	.O_EXT_CLK_IN_EN(O_EXT_CLK_IN_EN),
	.O_XTAL_PORT_MODE(O_XTAL_PORT_MODE),
	.O_SLOW_OSC_RUN(O_SLOW_OSC_RUN), .O_SLOW_TO_WDT(O_SLOW_TO_WDT),
	.O_SLOW_TO_TIMERS(O_SLOW_TO_TIMERS),
	.O_FLASH_HIGH_SPEED(O_FLASH_HIGH_SPEED),
	.O_FLASH_MODE_ERR(O_FLASH_MODE_ERR)
);

// *** verif/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int STD = 8;
	localparam int R48 = 12;
	logic        clk = 1'b0;
	logic        nrst, wr, rd, won, wsb, sby;
	logic [19:0] addr;
	logic [7:0]  wd, opt, rdat;
	logic        cst, gate, src, frun, halve, amp, ext, port;
	logic        srun, swdt, stmr, fhs, ferr;
	logic [4:0]  fsel;
	logic [2:0]  div;
	int          n_errors = 0;
	int          tests_run = 0;
	always #12.5 clk = ~clk;
	scc_clock_source_ctrl #(
		.HOCO_STAB_STD  (STD),
		.HOCO_STAB_RAW48(R48),
		.STAB_STEP      (2)
	) uut (
		.I_SYS_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wd),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .I_OPTION_BYTE(opt),
		.I_WATCHDOG_ON_OPTION(won), .I_WATCHDOG_STANDBY_RUN(wsb),
		.I_STANDBY(sby), .O_CPU_START(cst), .O_CPU_CLK_GATE(gate),
		.O_CPU_SRC_MAIN(src), .O_FAST_OSC_RUN(frun),
		.O_FAST_OSC_FREQ_SEL(fsel), .O_FAST_OSC_DIV(div),
		.O_FAST_OSC_HALVE(halve), .O_XTAL_AMP_EN(amp),
		.O_EXT_CLK_IN_EN(ext), .O_XTAL_PORT_MODE(port),
		.O_SLOW_OSC_RUN(srun), .O_SLOW_TO_WDT(swdt),
		.O_SLOW_TO_TIMERS(stmr), .O_FLASH_HIGH_SPEED(fhs),
		.O_FLASH_MODE_ERR(ferr)
	);
	scc_xtal_source_model xtal_src (
		.i_amp_en(amp), .i_ext_en(ext), .o_xtal_clock()
	);
	task automatic end_sim();
		if (n_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [19:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdat;
	endtask
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	// k 0 waits for cpu start, else for main source
	task automatic wait_hi(input int k, output int n);
		n = 0;
		while ((k == 0 ? cst : src) !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 200) begin
				n_errors++;
				$display("unexpected wait %0d expected 1 seen 0", k);
				end_sim();
			end
		end
	endtask
	task automatic do_reset(input logic [7:0] o, input logic w, s);
		int n;
		@(posedge clk);
		nrst <= 1'b0;
		opt <= o;
		won <= w;
		wsb <= s;
		sby <= 1'b0;
		repeat (20) @(posedge clk);
		#1;
		check("reset fast run", {7'h00, frun}, 8'h01);
		check("reset port", {7'h00, port}, 8'h01);
		@(posedge clk);
		nrst <= 1'b1;
		wait_hi(0, n);
		check("start late", 8'(n > (o[4] ? R48 : STD)), 8'h01);
		check("start src", {7'h00, src}, 8'h00);
		check("fast run", {7'h00, frun}, 8'h01);
	endtask
	task automatic t_table();
		logic [4:0] cd [7] = '{5'h10, 5'h00, 5'h09, 5'h01, 5'h0A, 5'h0B, 5'h0D};
		logic [7:0] o, d;
		for (int i = 0; i < 7; i++) begin
			o = {2'(i), 1'b1, cd[i]};
			do_reset(o, 1'b0, 1'b0);
			check("freq", {3'h0, fsel}, {3'h0, o[4:0]});
			check("div", {5'h00, div}, {5'h00, o[2:0]});
			check("halve", {7'h00, halve}, {7'h00, o[4]});
			check("flash hs", {7'h00, fhs}, {7'h00, o[7] & o[6]});
			check("flash err", {7'h00, ferr}, {7'h00, ~o[7]});
			reg_rd(scc_pkg::ADDR_OPTION, d);
			check("option", d, o);
		end
	endtask
	task automatic t_divider();
		int lows;
		logic [7:0] d;
		do_reset(8'hE9, 1'b0, 1'b0);
		lows = 0;
		reg_wr(scc_pkg::ADDR_DIVIDER, 8'h02);
		repeat (10) begin
			@(posedge clk);
			#1;
			if (gate !== 1'b1)
				lows++;
		end
		check("new div", {5'h00, div}, 8'h02);
		check("gate wait", 8'(lows), 8'h03);
		reg_rd(scc_pkg::ADDR_DIVIDER, d);
		check("div read", d, 8'h02);
		reg_rd(scc_pkg::ADDR_OPTION, d);
		check("option kept", d, 8'hE9);
		reg_rd(20'h00010, d);
		check("unmapped", d, 8'h00);
	endtask
	task automatic t_slow();
		logic wb, e, s, x;
		for (int w = 0; w < 3; w++) begin
			wb = (w != 0);
			do_reset(8'hE9, wb, 1'(w >> 1));
			for (int k = 0; k < 4; k++) begin
				e = 1'(k);
				s = 1'(k >> 1);
				reg_wr(scc_pkg::ADDR_SPEED_MODE, {3'h0, e, 4'h0});
				sby <= s;
				repeat (3) @(posedge clk);
				#1;
				x = (wb | e) & ~(wb & ~e & s & (w != 2));
				check("slow run", {7'h00, srun}, {7'h00, x});
				check("slow wdt", {7'h00, swdt}, {7'h00, x & wb});
				check("slow tmr", {7'h00, stmr}, {7'h00, x & e});
			end
		end
	endtask
	task automatic t_main();
		logic [7:0] d;
		int n;
		do_reset(8'hE9, 1'b0, 1'b0);
		reg_wr(scc_pkg::ADDR_CLK_MODE, 8'h40);
		reg_wr(scc_pkg::ADDR_CLK_STATUS, 8'h00);
		reg_wr(scc_pkg::ADDR_CLK_MODE, 8'hC0);
		settle();
		check("resonator", {5'h00, amp, ext, port}, 8'h04);
		// a switch asked for before the resonator has settled is dropped
		reg_wr(scc_pkg::ADDR_SYS_CLK, 8'h10);
		reg_rd(scc_pkg::ADDR_SYS_CLK, d);
		check("early switch", d, 8'h00);
		// ready only once the whole status thermometer is full
		d = 8'h00;
		for (n = 0; n < 50 && d[0] !== 1'b1; n++)
			reg_rd(scc_pkg::ADDR_STAB_STATUS, d);
		check("stable", {7'h00, d[0]}, 8'h01);
		reg_wr(scc_pkg::ADDR_SYS_CLK, 8'h10);
		wait_hi(1, n);
		reg_wr(scc_pkg::ADDR_CLK_STATUS, 8'h01);
		settle();
		check("fast stop", {7'h00, frun}, 8'h00);
		reg_rd(scc_pkg::ADDR_CLK_MODE, d);
		check("mode once", d, 8'h40);
		reg_wr(scc_pkg::ADDR_DIVIDER, 8'h03);
		reg_rd(scc_pkg::ADDR_DIVIDER, d);
		check("div on main", d, 8'h01);
		// pin clock: switch requested with no stabilization poll
		do_reset(8'hE9, 1'b0, 1'b0);
		reg_wr(scc_pkg::ADDR_CLK_MODE, 8'hC0);
		reg_wr(scc_pkg::ADDR_CLK_STATUS, 8'h00);
		reg_wr(scc_pkg::ADDR_SYS_CLK, 8'h10);
		wait_hi(1, n);
		check("ext clock", {5'h00, amp, ext, port}, 8'h02);
		reg_rd(scc_pkg::ADDR_SYS_CLK, d);
		check("sys clk", d, 8'h30);
		reg_rd(scc_pkg::ADDR_STATE, d);
		check("state", d, 8'h09);
		do_reset(8'hE9, 1'b0, 1'b0);
		reg_wr(scc_pkg::ADDR_CLK_MODE, 8'h00);
		reg_wr(scc_pkg::ADDR_CLK_STATUS, 8'h00);
		settle();
		check("port mode", {5'h00, amp, ext, port}, 8'h01);
	endtask
	initial begin
		nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 20'h00000;
		wd = 8'h00;
		opt = 8'hE9;
		won = 1'b0;
		wsb = 1'b0;
		sby = 1'b0;
		t_table();
		t_divider();
		t_slow();
		t_main();
		end_sim();
	end
endmodule
